// [hdl/pin_mux_pkg.sv]
/*
  Constants, register map and carrier types for the pin multiplexer of the
  digital and analog pin groups.
  Assumes a 32-bit APB register bus and one control-subsystem clock.
*/
package pin_mux_pkg;

  localparam int DIG_PINS  = 8;
  localparam int ANA_PINS  = 10;
  localparam int AIO_BITS  = 4;
  localparam int COMP_OUTS = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] DG_MODE_OFF  = 8'h00;
  localparam logic [7:0] DG_PUD_OFF   = 8'h04;
  localparam logic [7:0] DG_DATA_OFF  = 8'h08;
  localparam logic [7:0] DG_DIR_OFF   = 8'h0c;
  localparam logic [7:0] DG_FEN_OFF   = 8'h10;
  localparam logic [7:0] AG_MODE_OFF  = 8'h14;
  localparam logic [7:0] AG_DATA_OFF  = 8'h18;
  localparam logic [7:0] AG_DIR_OFF   = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [15:0] DG_MODE_RST = 16'h0000;
  localparam logic [7:0]  DG_PUD_RST  = 8'h00;
  localparam logic [7:0]  DG_DATA_RST = 8'h00;
  localparam logic [7:0]  DG_DIR_RST  = 8'h00;
  localparam logic [7:0]  DG_FEN_RST  = 8'h00;
  localparam logic [31:0] AG_MODE_RST = 32'haaaaaaaa;
  localparam logic [3:0]  AG_DATA_RST = 4'h0;
  localparam logic [3:0]  AG_DIR_RST  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Digital group mode codes; codes 1 and 2 are reserved.
  localparam logic [1:0] DG_MODE_GPIO = 2'h0;
  localparam logic [1:0] DG_MODE_COMP = 2'h3;

  // Comparator number (1 to 6) driven in mode 3 by each pin, 0 for none.
  localparam int COMP_MAP [0:DIG_PINS-1] = '{0, 1, 6, 2, 3, 4, 0, 5};

  // Converter channel of each analog pin: A0 to A7 are 0 to 7, B0 to B7 are 8 to 15.
  localparam int ANA_CHANNEL [0:ANA_PINS-1] = '{0, 2, 3, 4, 6, 7, 8, 11, 12, 15};

  // Converter channel of the pin behind each digital bit of the analog group.
  localparam int AIO_CHANNEL [0:AIO_BITS-1] = '{2, 4, 6, 12};

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive bundles.
  typedef struct packed {
    logic [DIG_PINS-1:0] out;
    logic [DIG_PINS-1:0] oe;
    logic [DIG_PINS-1:0] pullup_en;
  } dig_drive_t;

  typedef struct packed {
    logic [AIO_BITS-1:0] out;
    logic [AIO_BITS-1:0] oe;
  } aio_drive_t;

endpackage : pin_mux_pkg

// [hdl/gpio_analog_pin_mux.sv]
/*
  Pin multiplexer for the eight-pin digital group and the ten-pin analog
  group, with an APB register slave.
  Register words at byte offsets, narrow registers in the low bits:
    0x00 digital mode select, two bits per pin, 0 general purpose, 3 comparator.
    0x04 digital pullup disable, one bit per pin.
    0x08 digital data: writes the output latch, reads the gated pad input.
    0x0c digital direction, 1 drives the pin.
    0x10 digital function enable; 0 keeps the pin an analog input.
    0x14 analog mode select, bit 2c+1 for converter channel c, 1 analog.
    0x18 analog-group data: writes the output latch, reads the gated pad input.
    0x1c analog-group direction, 1 drives the pin.
  Other offsets answer the control CPU with an error; accesses by other masters read zero
  and their writes are dropped.
  The analog path enables are ordered A0, A2, A3, A4, A6, A7, B0, B3, B4, B7,
  and the four analog-group digital bits sit on A2, A4, A6 and B4.
  Read data is captured in the setup cycle, so no access has a wait state.
  Assumes pin inputs synchronous to clk and a sideband that marks accesses
  made by the control-subsystem CPU.
*/
// What this block does
// - Digital pins carry input, output or comparator.
// - Every digital pin has its own pullup.
// - Digital pins reset to analog, digital off.
// - Only the control CPU may access registers.
// - Mode picks output or a comparator signal.
// - Pullup-disable bit one turns pullup off.
// - Data and direction registers for eight bits.
// - Two-bit field per pin selects mode.
// - Bits 5:4 steer the third digital pin.
// - Modes 1 and 2 are reserved.
// - Mode 3 comparator order across the pins.
// - Ten analog pins, four also digital.
// - Analog group digital pins lack pullups.
// - Analog pins reset to analog mode.
// - Analog mux chooses analog or digital.
// - Data and direction for four analog-group bits.
// - Odd bit per pin: zero digital, one analog.
// - Bit 5 steers the A2 input pin.
// - Even analog mux bits do nothing.
// - Only A2, A4, A6, B4 go digital.
// - Each group has its own registers.
`timescale 1ns/10ps

module gpio_analog_pin_mux #(
  parameter int ADDR_W = 8
) (
  input  wire logic                      clk,                   // System clock, 10 MHz.
  input  wire logic                      resetn,                // Asynchronous reset, low.
  input  wire logic                      psel,                  // APB select.
  input  wire logic                      penable,               // APB access phase.
  input  wire logic                      pwrite,                // APB write.
  input  wire logic [ADDR_W-1:0]         paddr,                 // APB byte address.
  input  wire logic [31:0]               pwdata,                // APB write data.
  input  wire logic                      master_is_control_cpu, // Access by control CPU.
  output logic [31:0]                    prdata,                // APB read data.
  output logic                           pready,                // APB ready.
  output logic                           pslverr,               // APB error, unmapped.
  input  wire logic [7:0]                dpin_in,               // Digital group pad input.
  input  wire logic [5:0]                comp_out,              // Comparator 1 to 6 outputs.
  output pin_mux_pkg::dig_drive_t        dpin_drive,            // Digital group pad drive.
  input  wire logic [3:0]                aio_in,                // Analog group pad input.
  output pin_mux_pkg::aio_drive_t        aio_drive,             // Analog group pad drive.
  output logic [9:0]                     analog_path_en         // Pin joined to analog path.
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  // Only the synchronised copy resets the registers, so release meets no edge.
  logic        rst_meta_reg;
  logic        rst_sync_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [15:0] dg_mode_reg;
  logic [7:0]  dg_pud_reg;
  logic [7:0]  dg_data_reg;
  logic [7:0]  dg_dir_reg;
  logic [7:0]  dg_fen_reg;

  // Analog group registers, kept apart from the digital set.
  logic [31:0] ag_mode_reg;
  logic [3:0]  ag_data_reg;
  logic [3:0]  ag_dir_reg;

  // Gated pad inputs and the captured bus response.
  logic [7:0]  dg_in_reg;
  logic [3:0]  ag_in_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  logic        wr_en;
  logic [7:0]  addr8;
  logic        setup_rd;

  // Bit 2c+1 of the analog mode word joins channel c to the analog path.
  function automatic logic ag_is_analog(input logic [31:0] mode, input int chan);
    ag_is_analog = mode[2*chan+1];
  endfunction : ag_is_analog

  // Offsets outside this list answer the control CPU with an error.
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == pin_mux_pkg::DG_MODE_OFF) || (a == pin_mux_pkg::DG_PUD_OFF) ||
                  (a == pin_mux_pkg::DG_DATA_OFF) || (a == pin_mux_pkg::DG_DIR_OFF) ||
                  (a == pin_mux_pkg::DG_FEN_OFF)  || (a == pin_mux_pkg::AG_MODE_OFF) ||
                  (a == pin_mux_pkg::AG_DATA_OFF) || (a == pin_mux_pkg::AG_DIR_OFF);
  endfunction : addr_mapped

  assign addr8    = 8'(paddr);
  // Writes land at the access edge, and only for the control CPU.
  assign wr_en    = psel && penable && pwrite && master_is_control_cpu;
  assign setup_rd = psel && !penable;
  // Read data is captured one edge early, so no access needs a wait state.
  assign pready   = 1'b1;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Digital group registers, separate from the analog group set.
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      dg_mode_reg <= pin_mux_pkg::DG_MODE_RST;
      dg_pud_reg  <= pin_mux_pkg::DG_PUD_RST;
      dg_data_reg <= pin_mux_pkg::DG_DATA_RST;
      dg_dir_reg  <= pin_mux_pkg::DG_DIR_RST;
      dg_fen_reg  <= pin_mux_pkg::DG_FEN_RST;
    end
    else if (wr_en)
    begin
      unique case (addr8)
        pin_mux_pkg::DG_MODE_OFF: dg_mode_reg <= pwdata[15:0];
        pin_mux_pkg::DG_PUD_OFF:  dg_pud_reg  <= pwdata[7:0];
        pin_mux_pkg::DG_DATA_OFF: dg_data_reg <= pwdata[7:0];
        pin_mux_pkg::DG_DIR_OFF:  dg_dir_reg  <= pwdata[7:0];
        // Until its enable bit is set, a pin stays an analog input, pad undriven.
        pin_mux_pkg::DG_FEN_OFF:  dg_fen_reg  <= pwdata[7:0];
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog group registers.
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      ag_mode_reg <= pin_mux_pkg::AG_MODE_RST;
      ag_data_reg <= pin_mux_pkg::AG_DATA_RST;
      ag_dir_reg  <= pin_mux_pkg::AG_DIR_RST;
    end
    else if (wr_en)
    begin
      unique case (addr8)
        pin_mux_pkg::AG_MODE_OFF: ag_mode_reg <= pwdata;
        pin_mux_pkg::AG_DATA_OFF: ag_data_reg <= pwdata[3:0];
        pin_mux_pkg::AG_DIR_OFF:  ag_dir_reg  <= pwdata[3:0];
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital group routing.
  logic [7:0]  dg_out_next;
  logic [7:0]  dg_oe_next;
  logic [7:0]  dg_pull_next;
  logic [7:0]  dg_in_next;

  always_comb
  begin
    logic [1:0] mode;
    logic       gpio;
    logic       comp;
    mode = 2'h0;
    gpio = 1'b0;
    comp = 1'b0;
    dg_out_next  = 8'h00;
    dg_oe_next   = 8'h00;
    dg_pull_next = 8'h00;
    dg_in_next   = 8'h00;
    for (int i = 0; i < pin_mux_pkg::DIG_PINS; i++)
    begin
      mode = dg_mode_reg[2*i +: 2];
      gpio = dg_fen_reg[i] && (mode == pin_mux_pkg::DG_MODE_GPIO);
      // Reserved codes and pins without a comparator leave the pad undriven.
      comp = dg_fen_reg[i] && (mode == pin_mux_pkg::DG_MODE_COMP) &&
             (pin_mux_pkg::COMP_MAP[i] != 0);
      if (gpio)
      begin
        dg_out_next[i] = dg_data_reg[i];
        dg_oe_next[i]  = dg_dir_reg[i];
      end
      else if (comp)
      begin
        // Mode 3 drives the pad whatever the direction bit holds.
        dg_out_next[i] = comp_out[pin_mux_pkg::COMP_MAP[i] - 1];
        dg_oe_next[i]  = 1'b1;
      end
      else
      begin
        dg_out_next[i] = 1'b0;
        dg_oe_next[i]  = 1'b0;
      end
      dg_pull_next[i] = dg_fen_reg[i] && !dg_pud_reg[i];
      dg_in_next[i]   = gpio && dpin_in[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog group routing.
  logic [9:0]  ana_next;
  logic [3:0]  aio_out_next;
  logic [3:0]  aio_oe_next;
  logic [3:0]  aio_in_next;

  always_comb
  begin
    logic dig;
    dig = 1'b0;
    ana_next     = 10'h000;
    aio_out_next = 4'h0;
    aio_oe_next  = 4'h0;
    aio_in_next  = 4'h0;
    // Only the odd bits of the analog mode word steer a pin; even bits are kept.
    for (int k = 0; k < pin_mux_pkg::ANA_PINS; k++)
    begin
      ana_next[k] = ag_is_analog(ag_mode_reg, pin_mux_pkg::ANA_CHANNEL[k]);
    end
    for (int j = 0; j < pin_mux_pkg::AIO_BITS; j++)
    begin
      dig = !ag_is_analog(ag_mode_reg, pin_mux_pkg::AIO_CHANNEL[j]);
      aio_out_next[j] = dig && ag_data_reg[j];
      aio_oe_next[j]  = dig && ag_dir_reg[j];
      aio_in_next[j]  = dig && aio_in[j];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital group pad drive flip-flops.
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      dpin_drive <= '0;
    end
    else
    begin
      dpin_drive.out       <= dg_out_next;
      dpin_drive.oe        <= dg_oe_next;
      dpin_drive.pullup_en <= dg_pull_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog group pad drive and analog path flip-flops.
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      aio_drive      <= '0;
      analog_path_en <= '1;
    end
    else
    begin
      aio_drive.out  <= aio_out_next;
      aio_drive.oe   <= aio_oe_next;
      analog_path_en <= ana_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad input capture; a pin in analog mode reads back as zero.
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      dg_in_reg <= 8'h00;
      ag_in_reg <= 4'h0;
    end
    else
    begin
      dg_in_reg <= dg_in_next;
      ag_in_reg <= aio_in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle for a zero-wait access phase.
  // The data words return the gated pad inputs, not the output latches.
  logic [31:0] rd_value;

  always_comb
  begin
    rd_value = 32'h00000000;
    unique case (addr8)
      pin_mux_pkg::DG_MODE_OFF: rd_value = {16'h0000, dg_mode_reg};
      pin_mux_pkg::DG_PUD_OFF:  rd_value = {24'h000000, dg_pud_reg};
      pin_mux_pkg::DG_DATA_OFF: rd_value = {24'h000000, dg_in_reg};
      pin_mux_pkg::DG_DIR_OFF:  rd_value = {24'h000000, dg_dir_reg};
      pin_mux_pkg::DG_FEN_OFF:  rd_value = {24'h000000, dg_fen_reg};
      pin_mux_pkg::AG_MODE_OFF: rd_value = ag_mode_reg;
      pin_mux_pkg::AG_DATA_OFF: rd_value = {28'h0000000, ag_in_reg};
      pin_mux_pkg::AG_DIR_OFF:  rd_value = {28'h0000000, ag_dir_reg};
      default:                  rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (setup_rd)
    begin
      // Other masters see zero data and no error; their writes are dropped.
      prdata_reg  <= (!pwrite && master_is_control_cpu) ? rd_value : 32'h00000000;
      pslverr_reg <= master_is_control_cpu && !addr_mapped(addr8);
    end
  end

endmodule : gpio_analog_pin_mux

// [testbench/pin_mux_properties.sv]
/*
  Port assertions for the pin mux.
  Assumes it is bound to the design top from tb_top.
*/
`timescale 1ns/10ps
module pin_mux_properties #(
  parameter int ADDR_W = 8
) (
  input logic                    clk,                   // Clock.
  input logic                    resetn,                // Reset, low.
  input logic                    psel,                  // Select.
  input logic                    penable,               // Enable.
  input logic                    pwrite,                // Write.
  input logic [ADDR_W-1:0]       paddr,                 // Address.
  input logic [31:0]             pwdata,                // Write data.
  input logic                    master_is_control_cpu, // CPU access.
  input logic [31:0]             prdata,                // Read data.
  input logic                    pready,                // Ready.
  input logic                    pslverr,               // Error.
  input pin_mux_pkg::dig_drive_t dpin_drive,            // Digital drive.
  input pin_mux_pkg::aio_drive_t aio_drive,             // Analog drive.
  input logic [9:0]              analog_path_en         // Analog path.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [9:0] wmap;
  logic       bad;
  assign wmap = {pwdata[31], pwdata[25], pwdata[23], pwdata[17], pwdata[15],
                 pwdata[13], pwdata[9], pwdata[7], pwdata[5], pwdata[1]};
  assign bad = paddr > 8'h1c || paddr[1:0] != 2'h0;
  sequence quiet;
    dpin_drive == '0 && aio_drive == '0 && &analog_path_en;
  endsequence
  sequence acc;
    psel && penable;
  endsequence
  sequence ag_wr(ok);
    psel && penable && pwrite && master_is_control_cpu == ok
      && paddr == pin_mux_pkg::AG_MODE_OFF;
  endsequence
  a_reset_quiet: assert property ($rose(resetn) |-> quiet ##1 quiet)
    else $error("outputs left reset state early");
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_nocpu_read: assert property (psel && !penable && !pwrite && !master_is_control_cpu
    ##1 acc |-> prdata == 32'h0 && !pslverr)
    else $error("foreign read not blanked");
  a_unmapped_err: assert property (psel && !penable && !pwrite && master_is_control_cpu
    && bad ##1 acc |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (psel && !penable && master_is_control_cpu && !bad
    ##1 acc |-> !pslverr)
    else $error("mapped access refused");
  a_path_follow: assert property (ag_wr(1'b1) |-> ##2 analog_path_en == $past(wmap, 2))
    else $error("analog path does not follow odd bits");
  a_nocpu_write: assert property (ag_wr(1'b0) |-> ##2 $stable(analog_path_en))
    else $error("foreign write took effect");
  a_aio_gated: assert property (((aio_drive.out | aio_drive.oe) & {analog_path_en[8],
    analog_path_en[4], analog_path_en[3], analog_path_en[1]}) == 4'h0)
    else $error("analog pin driven digitally");
endmodule : pin_mux_properties

// [testbench/pad_model.sv]
/*
  Board pads and comparators around the pin mux.
  Assumes the bench sets the comparator levels.
*/
`timescale 1ns/10ps
module pad_model (
  input logic                    clk,      // Clock.
  input pin_mux_pkg::dig_drive_t dd,       // Digital drive.
  input pin_mux_pkg::aio_drive_t ad,       // Analog drive.
  input logic [5:0]              comp_set, // Comparator levels.
  output logic [7:0]             dpin_in,  // Digital pads.
  output logic [3:0]             aio_in,   // Analog pads.
  output logic [5:0]             comp_out  // Comparators.
);
  // Floating pads toggle so a stale value is never read back.
  logic flt = 1'b0;
  always @(posedge clk)
    flt <= ~flt;
  assign dpin_in = (dd.oe & dd.out) | (~dd.oe & (dd.pullup_en | {8{flt}}));
  assign aio_in = (ad.oe & ad.out) | (~ad.oe & {4{flt}});
  assign comp_out = comp_set;
endmodule : pad_model

// [testbench/tb_top.sv]
/*
  Self-checking bench for the pin mux with APB driver and read scoreboard.
  Assumes the design package and pad model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [7:0] dpin_in;
  logic [3:0] aio_in;
  logic [5:0] comp_out, comp_set = 6'h00;
  pin_mux_pkg::dig_drive_t dd;
  pin_mux_pkg::aio_drive_t ad;
  logic [9:0] ape;
  logic [32:0] q[$];
  int fail_count = 0, check_count = 0, seed = 7307, cyc = 0;
  localparam int CMAP [0:7] = '{0, 1, 6, 2, 3, 4, 0, 5};
  localparam int ABIT [0:9] = '{1, 5, 7, 9, 13, 15, 17, 23, 25, 31};
  localparam int XBIT [0:3] = '{5, 9, 13, 25};
  always #50 clk = ~clk;
  gpio_analog_pin_mux DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .master_is_control_cpu(cpu),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dpin_in(dpin_in),
    .comp_out(comp_out), .dpin_drive(dd), .aio_in(aio_in), .aio_drive(ad),
    .analog_path_en(ape));
  pad_model pads (.clk(clk), .dd(dd), .ad(ad), .comp_set(comp_set), .dpin_in(dpin_in),
    .aio_in(aio_in), .comp_out(comp_out));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, c, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    cpu <= c;
    paddr <= a;
    pwdata <= d;
    if (!w)
      q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  always @(posedge clk)
  begin
    cyc++;
    if (psel && penable && pready && !pwrite && q.size() > 0)
      check({pslverr, prdata}, q.pop_front());
    if (cyc > 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin : main
    logic [31:0] d, r, w;
    logic [7:0]  o, e;
    logic [9:0]  m;
    logic [3:0]  x;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    settle();
    check({dd, ad, ape}, {24'h0, 8'h0, 10'h3ff});
    for (int i = 0; i < 9; i++)
      apb(1'b0, 1'b1, 8'(i * 4), 32'h0, i == 8 ? 33'h100000000 : i == 5 ? 33'haaaaaaaa : 33'h0);
    apb(1'b0, 1'b1, 8'hfc, 32'h0, 33'h100000000);
    apb(1'b1, 1'b0, 8'h10, 32'hff, 33'h0);
    apb(1'b0, 1'b0, 8'h14, 32'h0, 33'h0);
    apb(1'b1, 1'b0, 8'h14, 32'h0, 33'h0);
    apb(1'b0, 1'b1, 8'h10, 32'h0, 33'h0);
    $display("done: reset and access");
    d = $random(seed);
    r = $random(seed);
    comp_set <= r[13:8];
    apb(1'b1, 1'b1, 8'h10, 32'hff, 33'h0);
    apb(1'b1, 1'b1, 8'h04, {24'h0, r[7:0]}, 33'h0);
    apb(1'b1, 1'b1, 8'h0c, 32'hff, 33'h0);
    apb(1'b1, 1'b1, 8'h08, {24'h0, d[7:0]}, 33'h0);
    settle();
    apb(1'b0, 1'b1, 8'h08, 32'h0, {25'h0, d[7:0]});
    for (int k = 0; k < 8; k++)
    begin
      w = $random(seed);
      apb(1'b1, 1'b1, 8'h00, w, 33'h0);
      settle();
      for (int i = 0; i < 8; i++)
      begin
        o[i] = w[2*i+:2] == 2'h0 ? d[i] : w[2*i+:2] == 2'h3 && CMAP[i] != 0 ? r[7+CMAP[i]] : 1'b0;
        e[i] = w[2*i+:2] == 2'h0 || (w[2*i+:2] == 2'h3 && CMAP[i] != 0);
      end
      check(dd, {o, e, ~r[7:0]});
    end
    apb(1'b1, 1'b1, 8'h00, 32'h0, 33'h0);
    apb(1'b1, 1'b1, 8'h0c, 32'h0, 33'h0);
    apb(1'b1, 1'b1, 8'h04, 32'h0, 33'h0);
    settle();
    check(dd, {d[7:0], 8'h00, 8'hff});
    apb(1'b0, 1'b1, 8'h08, 32'h0, 33'h0ff);
    $display("done: digital group");
    apb(1'b1, 1'b1, 8'h1c, 32'hf, 33'h0);
    apb(1'b1, 1'b1, 8'h18, {28'h0, d[11:8]}, 33'h0);
    for (int k = 0; k < 8; k++)
    begin
      w = $random(seed);
      apb(1'b1, 1'b1, 8'h14, w, 33'h0);
      settle();
      for (int i = 0; i < 10; i++)
        m[i] = w[ABIT[i]];
      for (int j = 0; j < 4; j++)
        x[j] = ~w[XBIT[j]];
      check({ad, ape}, {x & d[11:8], x, m});
      apb(1'b0, 1'b1, 8'h14, 32'h0, {1'b0, w});
      apb(1'b0, 1'b1, 8'h18, 32'h0, {29'h0, x & d[11:8]});
    end
    $display("done: analog group");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_top
bind gpio_analog_pin_mux pin_mux_properties #(.ADDR_W(ADDR_W)) props (.clk(clk),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .master_is_control_cpu(master_is_control_cpu), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dpin_drive(dpin_drive), .aio_drive(aio_drive),
  .analog_path_en(analog_path_en));
